// ===== design/csw_core_mem.sv
// status word, internal data memory and address space decoding
`timescale 1ns/1ps
`default_nettype none
module csw_core_mem
    import csw_pkg::*;
(
    input  wire logic              clk,           // core clock
    input  wire logic              sys_rst,       // async reset, high
    input  wire csw_alu_req_type   alu_req,       // flag update request
    input  wire logic [7:0]        acc_value,     // accumulator contents
    input  wire csw_idata_req_type idata_req,     // internal data access
    input  wire logic [7:0]        sfr_rdata,     // other special registers
    input  wire csw_xdata_req_type xdata_req,     // code/xdata access
    input  wire logic [7:0]        rom_rdata,     // rom fetch data
    output logic [7:0]             status_word_reg, // status word value
    output logic [7:0]             idata_rdata,   // internal read byte
    output logic                   idata_rbit,    // internal read bit
    output logic                   sfr_sel,       // access went to sfr space
    output logic [7:0]             sfr_addr,      // sfr byte address
    output logic [7:0]             xdata_rdata,   // code/xdata read byte
    output csw_region_type         xdata_region,  // decoded region
    output logic [15:0]            rom_addr       // rom fetch address
);
    logic [7:0]  iram [IDATA_DEPTH];
    logic [7:0]  next_status;
    logic [7:0]  next_idata_rdata;
    logic        next_idata_rbit;
    logic [7:0]  byte_addr;
    logic [2:0]  bit_pos;
    logic        to_sfr;
    logic        psw_hit;
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic [8:0]  diff9;
    logic [4:0]  diff5;
    logic [15:0] prod;
    logic        cin;
    logic [7:0]  psw_wr_val;
    logic        carry_flag;
    logic        aux_carry_flag;
    logic        overflow_flag;
    logic [1:0]  bank_select;

    assign carry_flag     = status_word_reg[CARRY_BIT];
    assign aux_carry_flag = status_word_reg[AUX_BIT];
    assign overflow_flag  = status_word_reg[OVF_BIT];
    assign bank_select    = status_word_reg[BANK_HI_BIT:BANK_LO_BIT];

    // resolve the byte address: register, bit area or plain byte
    always_comb begin
        bit_pos   = idata_req.addr[2:0];
        byte_addr = idata_req.addr;
        if (idata_req.is_reg)
            byte_addr = {3'h0, bank_select, idata_req.addr[2:0]};
        else if (idata_req.is_bit && !idata_req.addr[7])
            byte_addr = BITAREA_BASE + {4'h0, idata_req.addr[6:3]};
        else if (idata_req.is_bit)
            byte_addr = {idata_req.addr[7:3], 3'h0};
    end

    // direct above 0x7f goes to sfrs, indirect to upper ram
    assign to_sfr   = !idata_req.is_reg && !idata_req.indirect
                      && byte_addr >= UPPER_BASE;
    assign sfr_sel  = idata_req.en && to_sfr;
    assign sfr_addr = byte_addr;
    assign psw_hit  = idata_req.en && to_sfr && byte_addr == STATUS_WORD_ADDR;

    // arithmetic partial results
    always_comb begin
        cin   = (alu_req.op == CSW_OP_ADD_WITH_CARRY_OP || alu_req.op == CSW_OP_SUBTRACT_BORROW_OP) && carry_flag;
        sum9  = {1'b0, alu_req.lhs} + {1'b0, alu_req.rhs} + {8'h00, cin};
        sum5  = {1'b0, alu_req.lhs[3:0]} + {1'b0, alu_req.rhs[3:0]} + {4'h0, cin};
        diff9 = {1'b0, alu_req.lhs} - {1'b0, alu_req.rhs} - {8'h00, cin};
        diff5 = {1'b0, alu_req.lhs[3:0]} - {1'b0, alu_req.rhs[3:0]} - {4'h0, cin};
        prod  = alu_req.lhs * alu_req.rhs;
    end

    // value a software write would leave in the status word
    always_comb begin
        psw_wr_val = status_word_reg;
        if (idata_req.is_bit)
            psw_wr_val[bit_pos] = idata_req.wbit;
        else
            psw_wr_val = idata_req.wdata;
    end

    // status word next value; hardware flags win over a same-cycle write
    always_comb begin
        next_status = status_word_reg;
        if (idata_req.en && idata_req.wr && psw_hit)
            next_status = psw_wr_val;
        case (alu_req.op)
            CSW_OP_ADD, CSW_OP_ADD_WITH_CARRY_OP: begin
                next_status[CARRY_BIT] = sum9[8];
                next_status[AUX_BIT]   = sum5[4];
                next_status[OVF_BIT]   = (alu_req.lhs[7] == alu_req.rhs[7])
                                         && (sum9[7] != alu_req.lhs[7]);
            end
            CSW_OP_SUBTRACT_BORROW_OP: begin
                next_status[CARRY_BIT] = diff9[8];
                next_status[AUX_BIT]   = diff5[4];
                next_status[OVF_BIT]   = (alu_req.lhs[7] != alu_req.rhs[7])
                                         && (diff9[7] != alu_req.lhs[7]);
            end
            CSW_OP_MUL: begin
                next_status[CARRY_BIT] = 1'b0;
                next_status[OVF_BIT]   = prod[15:8] != 8'h00;
            end
            CSW_OP_DIV: begin
                next_status[CARRY_BIT] = 1'b0;
                next_status[OVF_BIT]   = alu_req.rhs == 8'h00;
            end
            CSW_OP_DA: begin
                // decimal adjust can only raise carry, never clear it
                next_status[CARRY_BIT] = carry_flag || sum9[8];
            end
            default: begin
                next_status[CARRY_BIT] = next_status[CARRY_BIT];
            end
        endcase
        next_status[PARITY_BIT] = ^acc_value;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            status_word_reg <= STATUS_WORD_RESET;
        else
            status_word_reg <= next_status;
    end

    // internal ram write; bit writes merge into the byte
    always_ff @(posedge clk) begin
        if (idata_req.en && idata_req.wr && !to_sfr) begin
            if (idata_req.is_bit)
                iram[byte_addr][bit_pos] <= idata_req.wbit;
            else
                iram[byte_addr] <= idata_req.wdata;
        end
    end

    // read mux: ram, status word or other special registers
    always_comb begin
        next_idata_rdata = idata_rdata;
        if (idata_req.en && !idata_req.wr) begin
            if (psw_hit)
                next_idata_rdata = status_word_reg;
            else if (to_sfr)
                next_idata_rdata = sfr_rdata;
            else
                next_idata_rdata = iram[byte_addr];
        end
        next_idata_rbit = next_idata_rdata[bit_pos];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idata_rdata <= 8'h00;
            idata_rbit  <= 1'b0;
        end else begin
            idata_rdata <= next_idata_rdata;
            idata_rbit  <= next_idata_rbit;
        end
    end

    // shared code/xdata space
    csw_xdata_map u_xmap (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .req       (xdata_req),
        .rom_rdata (rom_rdata),
        .rdata     (xdata_rdata),
        .region    (xdata_region),
        .rom_addr  (rom_addr)
    );

    carry_add_a: assert property (@(posedge clk) disable iff (sys_rst)
        (alu_req.op == CSW_OP_ADD) |=> status_word_reg[CARRY_BIT] == $past(sum9[8]))
        else $error("carry wrong after add");
    aux_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
        (alu_req.op == CSW_OP_SUBTRACT_BORROW_OP) |=> status_word_reg[AUX_BIT] == $past(diff5[4]))
        else $error("aux carry wrong after subtract");
    user_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
        !psw_hit |=> $stable(status_word_reg[USER0_BIT]) && $stable(status_word_reg[USER1_BIT]))
        else $error("user flag changed by hardware");
    bank_map_a: assert property (@(posedge clk) disable iff (sys_rst)
        idata_req.is_reg |-> byte_addr == {3'h0, status_word_reg[4:3], idata_req.addr[2:0]})
        else $error("register bank mapping wrong");
    ovf_mul_a: assert property (@(posedge clk) disable iff (sys_rst)
        (alu_req.op == CSW_OP_MUL) |=> status_word_reg[OVF_BIT] == ($past(prod) > 16'h00ff))
        else $error("overflow wrong after multiply");
    ovf_div_a: assert property (@(posedge clk) disable iff (sys_rst)
        (alu_req.op == CSW_OP_DIV && alu_req.rhs != 8'h00) |=> !status_word_reg[OVF_BIT])
        else $error("overflow not cleared after divide");
    direct_sfr_a: assert property (@(posedge clk) disable iff (sys_rst)
        (idata_req.en && !idata_req.indirect && !idata_req.is_bit && !idata_req.is_reg
         && idata_req.addr[7]) |-> sfr_sel)
        else $error("direct upper access missed sfr space");
    indirect_ram_a: assert property (@(posedge clk) disable iff (sys_rst)
        (idata_req.en && idata_req.indirect) |-> !sfr_sel)
        else $error("indirect access went to sfr space");
    bit_map_a: assert property (@(posedge clk) disable iff (sys_rst)
        (idata_req.is_bit && !idata_req.is_reg && idata_req.addr == 8'h13) |-> byte_addr == 8'h22)
        else $error("bit address mapping wrong");
    parity_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> status_word_reg[PARITY_BIT] == ^$past(acc_value))
        else $error("parity does not follow accumulator");
endmodule : csw_core_mem
`default_nettype wire

// ===== include/csw_pkg.sv
// constants and carrier types for the status word and memory map block
// Operation
// - carry flag bit 7 set on add carry or subtract borrow, else cleared
// - aux carry bit 6 set on carry into or borrow from upper nibble
// - bits 5 and 1 are software flags, never changed by hardware
// - bank select bits 4:3 map R0-R7 to 0x00, 0x08, 0x10, 0x18 bases
// - overflow bit 2 set on signed overflow of add, add_with_carry_op, subtract_borrow_op
// - overflow set on multiply product above 255 or divide by zero
// - those five instructions clear overflow in every other case
// - status word is 8-bit at address 0xd0, byte and bit access, resets zero
// - upper 128 bytes indirect only; direct there selects special registers
// - lower 128 bytes reached by direct and indirect addressing
// - first 32 bytes are four banks of eight working registers
// - 16 bytes after banks accessible as bytes and as bits
// - code and data share one space; instruction kind picks the view
// - 4.5KB unified ram serves code fetch and external data read/write
// - 12KB rom executable, but user reads are prevented
// - 256-byte control register window decoded apart from the ram
// - code-move or data-move reads of rom return undetermined value
// - bit addresses 0x00-0x7f start at bit 0 of byte 0x20
// - multi-byte control registers are big endian, msb at lowest address
package csw_pkg;
    localparam logic [7:0]  STATUS_WORD_ADDR  = 8'hd0;
    localparam logic [7:0]  STATUS_WORD_RESET = 8'h00;
    localparam int          CARRY_BIT         = 7;
    localparam int          AUX_BIT           = 6;
    localparam int          USER0_BIT         = 5;
    localparam int          BANK_HI_BIT       = 4;
    localparam int          BANK_LO_BIT       = 3;
    localparam int          OVF_BIT           = 2;
    localparam int          USER1_BIT         = 1;
    localparam int          PARITY_BIT        = 0;
    localparam logic [7:0]  UPPER_BASE        = 8'h80;
    localparam logic [7:0]  BITAREA_BASE      = 8'h20;
    localparam logic [7:0]  BITAREA_SFR_BASE  = 8'h80;
    localparam int          IDATA_DEPTH       = 256;
    localparam logic [15:0] RAM_FIRST         = 16'h0000;
    localparam logic [15:0] RAM_LAST          = 16'h11ff;
    localparam logic [15:0] XDATA_HW_REGS_FIRST        = 16'h4000;
    localparam logic [15:0] XDATA_HW_REGS_LAST         = 16'h40ff;
    localparam logic [15:0] ROM_FIRST         = 16'h8000;
    localparam logic [15:0] ROM_LAST          = 16'hafff;
    localparam int          RAM_DEPTH         = 4608;
    localparam int          XDATA_HW_REGS_DEPTH        = 256;
    localparam logic [7:0]  ROM_READ_FILL     = 8'hff;

    // arithmetic operation kinds that touch the flags
    typedef enum logic [2:0] {
        CSW_OP_NONE = 3'h0,
        CSW_OP_ADD  = 3'h1,
        CSW_OP_ADD_WITH_CARRY_OP = 3'h3,
        CSW_OP_SUBTRACT_BORROW_OP = 3'h2,
        CSW_OP_MUL  = 3'h6,
        CSW_OP_DIV  = 3'h7,
        CSW_OP_DA   = 3'h5
    } csw_op_type;

    // one flag update request from the datapath
    typedef struct packed {
        csw_op_type op;
        logic [7:0] lhs;
        logic [7:0] rhs;
    } csw_alu_req_type;

    // internal data access
    typedef struct packed {
        logic       en;
        logic       wr;
        logic       indirect;
        logic       is_bit;
        logic       is_reg;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wbit;
    } csw_idata_req_type;

    // code/xdata access; fetch is an instruction fetch, else a data move
    typedef struct packed {
        logic        en;
        logic        wr;
        logic        fetch;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } csw_xdata_req_type;

    // regions of the shared space
    typedef enum logic [1:0] {
        CSW_RGN_NONE = 2'h0,
        CSW_RGN_RAM  = 2'h1,
        CSW_RGN_XDATA_HW_REGS = 2'h3,
        CSW_RGN_ROM  = 2'h2
    } csw_region_type;
endpackage : csw_pkg

// ===== design/csw_xdata_map.sv
// code/xdata decoder with unified ram and control register window
`timescale 1ns/1ps
`default_nettype none
module csw_xdata_map
    import csw_pkg::*;
(
    input  wire logic              clk,        // core clock
    input  wire logic              sys_rst,    // async reset, high
    input  wire csw_xdata_req_type req,        // access request
    input  wire logic [7:0]        rom_rdata,  // rom data for fetches
    output logic [7:0]             rdata,      // registered read data
    output csw_region_type         region,     // decoded region
    output logic [15:0]            rom_addr    // rom fetch address
);
    logic [7:0]     ram  [RAM_DEPTH];
    logic [7:0]     xdata_hw_regs [XDATA_HW_REGS_DEPTH];
    logic [7:0]     next_rdata;
    logic [12:0]    ram_idx;

    // decode the shared space by address only
    always_comb begin
        if (req.addr <= RAM_LAST)
            region = CSW_RGN_RAM;
        else if (req.addr >= XDATA_HW_REGS_FIRST && req.addr <= XDATA_HW_REGS_LAST)
            region = CSW_RGN_XDATA_HW_REGS;
        else if (req.addr >= ROM_FIRST && req.addr <= ROM_LAST)
            region = CSW_RGN_ROM;
        else
            region = CSW_RGN_NONE;
    end

    assign ram_idx  = req.addr[12:0] - RAM_FIRST[12:0];
    assign rom_addr = req.addr - ROM_FIRST;

    // read path; rom only answers fetches, moves see a fill value
    always_comb begin
        next_rdata = rdata;
        if (req.en && !req.wr) begin
            case (region)
                CSW_RGN_RAM:  next_rdata = ram[ram_idx];
                CSW_RGN_XDATA_HW_REGS: next_rdata = xdata_hw_regs[req.addr[7:0]];
                CSW_RGN_ROM:  next_rdata = req.fetch ? rom_rdata
                                                     : ROM_READ_FILL;
                default:      next_rdata = ROM_READ_FILL;
            endcase
        end
    end

    // memories carry no reset; software writes before use
    always_ff @(posedge clk) begin
        if (req.en && req.wr && !req.fetch && region == CSW_RGN_RAM)
            ram[ram_idx] <= req.wdata;
        if (req.en && req.wr && !req.fetch && region == CSW_RGN_XDATA_HW_REGS)
            xdata_hw_regs[req.addr[7:0]] <= req.wdata;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            rdata <= 8'h00;
        else
            rdata <= next_rdata;
    end

    // data moves from rom never see its contents
    rom_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
        (req.en && !req.wr && !req.fetch && region == CSW_RGN_ROM)
            |=> rdata == ROM_READ_FILL)
        else $error("rom data read leaked contents");
    ram_decode_a: assert property (@(posedge clk) disable iff (sys_rst)
        (req.addr == 16'h11ff) |-> region == CSW_RGN_RAM)
        else $error("ram upper bound misdecoded");
    xdata_hw_regs_decode_a: assert property (@(posedge clk) disable iff (sys_rst)
        (req.addr == 16'h1200 || req.addr == 16'h4100) |-> region == CSW_RGN_NONE)
        else $error("window bound misdecoded");
endmodule : csw_xdata_map
`default_nettype wire

// ===== testbench/csw_cpu_model.sv
// behavioural datapath side: other special registers and rom contents
`timescale 1ns/1ps
`default_nettype none
module csw_cpu_model (
    input  wire logic        clk,       // core clock
    input  wire logic        sfr_sel,   // access goes to sfr space
    input  wire logic [7:0]  sfr_addr,  // sfr byte address
    input  wire logic [15:0] rom_addr,  // rom fetch address
    output logic [7:0]       sfr_rdata, // other special registers
    output logic [7:0]       rom_rdata  // rom contents
);
    logic [7:0] idle_pat = 8'h00;

    // unselected bus keeps moving so a stale value never passes as data
    always_ff @(posedge clk) begin
        idle_pat <= idle_pat + 8'h35;
    end

    // sfr and rom contents are address patterns the bench can predict
    assign sfr_rdata = sfr_sel ? (sfr_addr ^ 8'h3c) : idle_pat;
    assign rom_rdata = rom_addr[7:0] ^ 8'h5c;
endmodule : csw_cpu_model
`default_nettype wire

// ===== testbench/csw_core_mem_tb.sv
// self-checking bench for the status word and memory map block
`timescale 1ns/1ps
`default_nettype none
module csw_core_mem_tb
    import csw_pkg::*;
;
    typedef struct packed {
        csw_op_type op;
        logic [7:0] lhs;
        logic [7:0] rhs;
        logic [7:0] mask;
        logic [7:0] flags;
    } csw_row_type;

    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    csw_alu_req_type   alu_req = '0;
    logic [7:0]        acc_value = 8'h00;
    csw_idata_req_type idata_req = '0;
    csw_xdata_req_type xdata_req = '0;
    wire logic [7:0]   sfr_rdata, rom_rdata, status_word_reg, idata_rdata, sfr_addr, xdata_rdata;
    wire logic         idata_rbit, sfr_sel;
    wire csw_region_type xdata_region;
    wire logic [15:0]  rom_addr;
    logic              sel_seen;
    logic [1:0]        rgn_seen;
    logic [15:0]       rom_seen;
    int                error_cnt = 0;
    int                n_checks = 0;

    // rows run in order: carry in of add_with_carry_op and subtract_borrow_op comes from the row before
    // decimal adjust gets its correction value from the datapath in rhs
    csw_row_type rows [12] = '{
        '{CSW_OP_ADD,  8'hff, 8'h01, 8'hc4, 8'hc0}, '{CSW_OP_ADD_WITH_CARRY_OP, 8'h7f, 8'h00, 8'hc4, 8'h44},
        '{CSW_OP_SUBTRACT_BORROW_OP, 8'h80, 8'h01, 8'hc4, 8'h44}, '{CSW_OP_SUBTRACT_BORROW_OP, 8'h00, 8'h01, 8'hc4, 8'hc0},
        '{CSW_OP_MUL,  8'h10, 8'h10, 8'h84, 8'h04}, '{CSW_OP_MUL,  8'h0f, 8'h11, 8'h84, 8'h00},
        '{CSW_OP_DIV,  8'h10, 8'h00, 8'h84, 8'h04}, '{CSW_OP_DIV,  8'h10, 8'h03, 8'h84, 8'h00},
        '{CSW_OP_DA,   8'h9a, 8'h66, 8'h80, 8'h80}, '{CSW_OP_ADD,  8'h08, 8'h08, 8'hc4, 8'h40},
        '{CSW_OP_ADD,  8'h80, 8'h80, 8'hc4, 8'h84}, '{CSW_OP_SUBTRACT_BORROW_OP, 8'h10, 8'h01, 8'hc4, 8'h40}};
    logic [15:0]    rgn_addr [9] = '{16'h0000, 16'h11ff, 16'h1200, 16'h4000, 16'h40ff,
                                     16'h4100, 16'h8000, 16'hafff, 16'hb000};
    csw_region_type rgn_exp [9]  = '{CSW_RGN_RAM, CSW_RGN_RAM, CSW_RGN_NONE, CSW_RGN_XDATA_HW_REGS,
                                     CSW_RGN_XDATA_HW_REGS, CSW_RGN_NONE, CSW_RGN_ROM, CSW_RGN_ROM,
                                     CSW_RGN_NONE};

    csw_core_mem dut_u (
        .clk(clk), .sys_rst(sys_rst), .alu_req(alu_req), .acc_value(acc_value),
        .idata_req(idata_req), .sfr_rdata(sfr_rdata), .xdata_req(xdata_req),
        .rom_rdata(rom_rdata), .status_word_reg(status_word_reg), .idata_rdata(idata_rdata),
        .idata_rbit(idata_rbit), .sfr_sel(sfr_sel), .sfr_addr(sfr_addr),
        .xdata_rdata(xdata_rdata), .xdata_region(xdata_region), .rom_addr(rom_addr)
    );

    csw_cpu_model model_u (
        .clk(clk), .sfr_sel(sfr_sel), .sfr_addr(sfr_addr), .rom_addr(rom_addr),
        .sfr_rdata(sfr_rdata), .rom_rdata(rom_rdata)
    );

    // 40 MHz core clock
    always #12.5 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one internal access; the comb select is sampled while the request stands
    task automatic idata(input logic wr, ind, bitm, isreg, input logic [7:0] addr, wdata,
                         input logic wbit);
        @(posedge clk);
        idata_req <= '{1'b1, wr, ind, bitm, isreg, addr, wdata, wbit};
        #1 sel_seen = sfr_sel;
        @(posedge clk);
        idata_req.en <= 1'b0;
        #1;
    endtask : idata

    // one code/xdata access, region and rom address captured mid-request
    task automatic xd(input logic wr, fetch, input logic [15:0] addr, input logic [7:0] wdata);
        @(posedge clk);
        xdata_req <= '{1'b1, wr, fetch, addr, wdata};
        #1 rgn_seen = xdata_region;
        rom_seen = rom_addr;
        @(posedge clk);
        xdata_req.en <= 1'b0;
        #1;
    endtask : xd

    task automatic final_report;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // hang guard; the whole sequence needs about 140 cycles
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        #1 check("status reset", status_word_reg, STATUS_WORD_RESET);
        check("idata reset", idata_rdata, 8'h00);
        check("xdata reset", xdata_rdata, 8'h00);
        // user flags set first so the alu rows can show they are left alone
        idata(1, 0, 0, 0, STATUS_WORD_ADDR, 8'h22, 1'b0);
        foreach (rows[i]) begin
            @(posedge clk);
            alu_req <= '{rows[i].op, rows[i].lhs, rows[i].rhs};
            @(posedge clk);
            alu_req.op <= CSW_OP_NONE;
            #1 check("alu flags", status_word_reg & rows[i].mask, rows[i].flags);
        end
        check("user flags", status_word_reg & 8'h3a, 8'h22);
        // byte write with parity bit set, then a bit write clearing flag zero
        idata(1, 0, 0, 0, STATUS_WORD_ADDR, 8'h3b, 1'b0);
        check("status byte write", status_word_reg, 8'h3a);
        idata(1, 0, 1, 0, 8'hd5, 8'h00, 1'b0);
        check("status bit write", status_word_reg, 8'h1a);
        idata(0, 0, 1, 0, 8'hd4, 8'h00, 1'b0);
        check("status bit read", idata_rbit, 1'b1);
        @(posedge clk);
        acc_value <= 8'h07;
        repeat (2) @(posedge clk);
        #1 check("parity odd", status_word_reg[0], 1'b1);
        idata(1, 0, 0, 0, STATUS_WORD_ADDR, 8'h1a, 1'b0);
        check("parity write", status_word_reg[0], 1'b1);
        @(posedge clk);
        acc_value <= 8'h03;
        repeat (2) @(posedge clk);
        #1 check("parity even", status_word_reg[0], 1'b0);
        // each bank: register write lands at its own base
        for (int b = 0; b < 4; b++) begin
            idata(1, 0, 0, 0, STATUS_WORD_ADDR, 8'(b << 3), 1'b0);
            idata(1, 0, 0, 1, 8'h05, 8'h40 + 8'(b), 1'b0);
            idata(0, 0, 0, 0, 8'(8 * b + 5), 8'h00, 1'b0);
            check("bank register", idata_rdata, 8'h40 + 8'(b));
        end
        // upper ram through indirect only; direct there goes to sfrs
        idata(1, 1, 0, 0, 8'h90, 8'h5a, 1'b0);
        idata(1, 0, 0, 0, 8'h90, 8'h00, 1'b0);
        check("direct upper sel", sel_seen, 1'b1);
        idata(0, 0, 0, 0, 8'h90, 8'h00, 1'b0);
        check("sfr read", idata_rdata, 8'hac);
        idata(0, 1, 0, 0, 8'h90, 8'h00, 1'b0);
        check("upper indirect", idata_rdata, 8'h5a);
        check("indirect sel", sel_seen, 1'b0);
        idata(1, 0, 0, 0, 8'h30, 8'h77, 1'b0);
        idata(0, 1, 0, 0, 8'h30, 8'h00, 1'b0);
        check("lower indirect", idata_rdata, 8'h77);
        // bit 0x13 is bit 3 of byte 0x22, bit 0x7f is bit 7 of 0x2f
        idata(1, 0, 0, 0, 8'h22, 8'h00, 1'b0);
        idata(1, 0, 1, 0, 8'h13, 8'h00, 1'b1);
        idata(0, 0, 0, 0, 8'h22, 8'h00, 1'b0);
        check("bit area byte", idata_rdata, 8'h08);
        idata(1, 0, 0, 0, 8'h2f, 8'h80, 1'b0);
        idata(0, 0, 1, 0, 8'h7f, 8'h00, 1'b0);
        check("bit area bit", idata_rbit, 1'b1);
        // shared space: ram edges, control window apart from ram, rom hidden
        xd(1, 0, 16'h0000, 8'hab);
        xd(1, 0, 16'h11ff, 8'hcd);
        xd(1, 0, 16'h4000, 8'h12);
        xd(0, 1, 16'h11ff, 8'h00);
        check("ram fetch", xdata_rdata, 8'hcd);
        // a write flagged as fetch must leave the ram alone
        xd(1, 1, 16'h0000, 8'hee);
        xd(0, 0, 16'h0000, 8'h00);
        check("ram data", xdata_rdata, 8'hab);
        xd(0, 0, 16'h4000, 8'h00);
        check("window data", xdata_rdata, 8'h12);
        xd(1, 0, 16'h4001, 8'h34);
        xd(0, 0, 16'h4001, 8'h00);
        check("window next byte", xdata_rdata, 8'h34);
        xd(0, 0, 16'h8004, 8'h00);
        check("rom data read", xdata_rdata, ROM_READ_FILL);
        xd(0, 1, 16'h8004, 8'h00);
        check("rom fetch", xdata_rdata, 8'h58);
        check("rom address", rom_seen, 16'h0004);
        foreach (rgn_addr[i]) begin
            xd(0, 0, rgn_addr[i], 8'h00);
            check("region", rgn_seen, rgn_exp[i]);
        end
        // mid-run reset clears the registers but keeps memory contents
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1 check("status mid reset", status_word_reg, STATUS_WORD_RESET);
        check("idata mid reset", idata_rdata, 8'h00);
        check("xdata mid reset", xdata_rdata, 8'h00);
        xd(0, 0, 16'h4000, 8'h00);
        check("window kept", xdata_rdata, 8'h12);
        final_report();
    end
endmodule : csw_core_mem_tb
`default_nettype wire
